// ===== core/aumx_cfg.svh
// Timing, offsets and reset values of the AUI two-port multiplexer control.
// Assumes a 50 MHz aclk; every interval is counted from it.
`ifndef AUMX_CFG_SVH
`define AUMX_CFG_SVH
`define AUMX_CLK_NS 20
`define AUMX_IDLE_NS 180
`define AUMX_IDLE_CYC ((`AUMX_IDLE_NS + `AUMX_CLK_NS - 1) / `AUMX_CLK_NS)
`define AUMX_HOLD_NS 300
`define AUMX_HOLD_CYC (`AUMX_HOLD_NS / `AUMX_CLK_NS)
`define AUMX_OSC_PER 5
`define AUMX_OSC_HIGH 2
`define AUMX_SQE_DLY_NS 1100
`define AUMX_SQE_DUR_NS 1000
`define AUMX_SQE_DUR_CYC (`AUMX_SQE_DUR_NS / `AUMX_CLK_NS)
`define AUMX_SQE_TOT_CYC ((`AUMX_SQE_DLY_NS + `AUMX_SQE_DUR_NS) / `AUMX_CLK_NS)
`define AUMX_BLANK_NS 5000
`define AUMX_BLANK_CYC (`AUMX_BLANK_NS / `AUMX_CLK_NS)
`define AUMX_JAB_US 13500
`define AUMX_UNJAB_MS 500
`define AUMX_LED_MS 50
`define AUMX_CTRL_OFS 8'h00
`define AUMX_STAT_OFS 8'h04
`define AUMX_CTRL_RST 2'h3
`define AUMX_RESP_OKAY 2'h0
`define AUMX_RESP_SLVERR 2'h2
`endif

// ===== core/aumx_pkg.sv
// Types shared by the multiplexer control and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package aumx_pkg;
  typedef enum logic [2:0] {
    AUMX_JB_IDLE = 3'h1,
    AUMX_JB_RUN = 3'h2,
    AUMX_JB_JAB = 3'h4
  } aumx_jab_e;
  typedef enum logic [1:0] {
    AUMX_LVL_GND = 2'h0,
    AUMX_LVL_MID = 2'h1,
    AUMX_LVL_HIGH = 2'h2
  } aumx_lvl_e;
  typedef struct packed {
    logic [21:0] rsvd;
    logic jab_en;
    logic sqe_en;
    logic loop_en;
    logic coll;
    logic [1:0] jabbed;
    logic [3:0] act;
  } aumx_stat_s;
  typedef struct packed {
    logic [1:0] send_n;
    logic jab_lamp_port2_n;
    logic coll_n;
  } aumx_lamp_s;
endpackage

// ===== core/aumx_top.sv
// Control logic of a two-port AUI multiplexer with AXI4-Lite registers.
// Assumes inputs are digital squelch-front-end levels synchronous to aclk.
//
// How it works
// - qualified MAU receive data is copied to both DTE receive outputs.
// - MAU receive input uses the same squelch as the DTE send inputs.
// - an unsquelched input stays active until idle for more than 180 ns.
// - both DTE send inputs active together is a local collision.
// - MAU collision input outside the SQE test window is a collision.
// - collision drives a 10 MHz wave, high 2 of every 5 cycles, on both DTE collision outputs.
// - collision signal starts within 2 bit times, stops 2-5 bit times after.
// - port 1 wins the MAU send output; port 2 resumes when port 1 stops.
// - MAU collision input counts only after squelch qualification.
// - loopback echoes sending port data to both DTE receive outputs.
// - loopback is on when the receive lamp pin sits at ground or 0.6 V.
// - after each packet the sending port sees about 1 us of collision.
// - no SQE test pulse on a port in the jabber state.
// - SQE test only when the receive lamp pin is grounded.
// - each DTE input has a jabber timer spanning one packet.
// - packet over the jabber limit disables the input and drives collision.
// - jabbered port recovers after 0.5 s continuous idle; activity restarts it.
// - grounding the port 1 jabber lamp pin disables jabber on both ports.
// - active-low lamps for send, jabber, receive and collision.
// - send, receive, collision lamps stretched to 50 ms; jabber lamps not.
// - dual-role pins are straps when low or 0.6 V, lamps when pulled high.
// - after a packet, remote collision is blanked 5 us on both DTE collision outputs.
`include "aumx_cfg.svh"

module aumx_top #(
  parameter int JAB_CYC = `AUMX_JAB_US * 1000 / `AUMX_CLK_NS,
  parameter int UNJAB_CYC = `AUMX_UNJAB_MS * 1000000 / `AUMX_CLK_NS,
  parameter int LED_CYC = `AUMX_LED_MS * 1000000 / `AUMX_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port1_send_in,
  input wire logic port2_send_in,
  input wire logic mau_recv_in,
  input wire logic mau_collision_in,
  output logic mau_send_out,
  output logic [1:0] dte_recv_out,
  output logic [1:0] dte_collision_out,
  input wire aumx_pkg::aumx_lvl_e recv_lamp_cfg_pin_i,
  output logic recv_lamp_cfg_pin_o,
  output logic recv_lamp_cfg_pin_oe,
  input wire logic jab_lamp1_cfg_pin_i,
  output logic jab_lamp1_cfg_pin_o,
  output logic jab_lamp1_cfg_pin_oe,
  output aumx_pkg::aumx_lamp_s lamps
);
  import aumx_pkg::*;

  // ==========================================================
  // Strap capture
  logic strap_done_q;
  aumx_lvl_e rx_cfg_q;
  logic jab_gnd_q;
  logic [1:0] ctrl_q;
  logic loop_en;
  logic sqe_en;
  logic jab_en;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_done_q <= 1'b0;
      rx_cfg_q <= AUMX_LVL_HIGH;
      jab_gnd_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      rx_cfg_q <= recv_lamp_cfg_pin_i;
      jab_gnd_q <= !jab_lamp1_cfg_pin_i;
    end
  end

  assign loop_en = (rx_cfg_q == AUMX_LVL_GND) || (rx_cfg_q == AUMX_LVL_MID);
  assign sqe_en = (rx_cfg_q == AUMX_LVL_GND) && ctrl_q[0];
  assign jab_en = !jab_gnd_q && ctrl_q[1];

  // ==========================================================
  // Squelch qualification, one per receiver
  logic [3:0] raw;
  logic [3:0] act_q;
  logic [3:0] idle_cnt_q [4];

  assign raw = {mau_collision_in, mau_recv_in, port2_send_in, port1_send_in};

  for (genvar i = 0; i < 4; i++) begin : g_sq
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        act_q[i] <= 1'b0;
        idle_cnt_q[i] <= 4'h0;
      end else if (raw[i]) begin
        act_q[i] <= 1'b1;
        idle_cnt_q[i] <= 4'h0;
      end else if (act_q[i]) begin
        if (idle_cnt_q[i] == 4'(`AUMX_IDLE_CYC)) begin
          act_q[i] <= 1'b0;
          idle_cnt_q[i] <= 4'h0;
        end else begin
          idle_cnt_q[i] <= idle_cnt_q[i] + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // Jabber timers and SQE test, per DTE port
  aumx_jab_e jst_q [2];
  logic [24:0] jab_cnt_q [2];
  logic [1:0] jabbed;
  logic [1:0] tx_act;
  logic [1:0] tx_prev_q;
  logic [1:0] tx_end;
  logic [6:0] sqe_cnt_q [2];
  logic [1:0] sqe_on;

  for (genvar p = 0; p < 2; p++) begin : g_port
    assign jabbed[p] = (jst_q[p] == AUMX_JB_JAB);
    assign tx_act[p] = act_q[p] && !jabbed[p];
    assign tx_end[p] = tx_prev_q[p] && !act_q[p] && !jabbed[p];
    assign sqe_on[p] = (sqe_cnt_q[p] != 7'h0) && (sqe_cnt_q[p] <= 7'(`AUMX_SQE_DUR_CYC));

    always_ff @(posedge aclk) begin
      if (!aresetn || !jab_en) begin
        jst_q[p] <= AUMX_JB_IDLE;
        jab_cnt_q[p] <= 25'h0;
      end else begin
        unique case (jst_q[p])
          AUMX_JB_IDLE: begin
            jab_cnt_q[p] <= 25'h0;
            if (act_q[p]) begin
              jst_q[p] <= AUMX_JB_RUN;
            end
          end
          AUMX_JB_RUN: begin
            jab_cnt_q[p] <= jab_cnt_q[p] + 25'h1;
            if (!act_q[p]) begin
              jst_q[p] <= AUMX_JB_IDLE;
            end else if (jab_cnt_q[p] == 25'(JAB_CYC - 1)) begin
              jst_q[p] <= AUMX_JB_JAB;
              jab_cnt_q[p] <= 25'h0;
            end
          end
          AUMX_JB_JAB: begin
            if (act_q[p]) begin
              jab_cnt_q[p] <= 25'h0;
            end else if (jab_cnt_q[p] == 25'(UNJAB_CYC - 1)) begin
              jst_q[p] <= AUMX_JB_IDLE;
              jab_cnt_q[p] <= 25'h0;
            end else begin
              jab_cnt_q[p] <= jab_cnt_q[p] + 25'h1;
            end
          end
          default: begin
            jst_q[p] <= AUMX_JB_IDLE;
            jab_cnt_q[p] <= 25'h0;
          end
        endcase
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tx_prev_q[p] <= 1'b0;
      end else begin
        tx_prev_q[p] <= tx_act[p];
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn || jabbed[p]) begin
        sqe_cnt_q[p] <= 7'h0;
      end else if (tx_end[p] && sqe_en) begin
        sqe_cnt_q[p] <= 7'(`AUMX_SQE_TOT_CYC);
      end else if (sqe_cnt_q[p] != 7'h0) begin
        sqe_cnt_q[p] <= sqe_cnt_q[p] - 7'h1;
      end
    end
  end

  // ==========================================================
  // Collision detection and hold
  logic [7:0] blank_cnt_q;
  logic coll_local;
  logic coll_remote;
  logic coll_cond;
  logic [3:0] coll_hold_q;
  logic coll_on;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_cnt_q <= 8'h0;
    end else if (|tx_end) begin
      blank_cnt_q <= 8'(`AUMX_BLANK_CYC);
    end else if (blank_cnt_q != 8'h0) begin
      blank_cnt_q <= blank_cnt_q - 8'h1;
    end
  end

  assign coll_local = &tx_act;
  assign coll_remote = act_q[3] && (blank_cnt_q == 8'h0);
  assign coll_cond = coll_local || coll_remote;
  assign coll_on = coll_cond || (coll_hold_q != 4'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coll_hold_q <= 4'h0;
    end else if (coll_cond) begin
      coll_hold_q <= 4'(`AUMX_HOLD_CYC);
    end else if (coll_hold_q != 4'h0) begin
      coll_hold_q <= coll_hold_q - 4'h1;
    end
  end

  // ==========================================================
  // Collision oscillator and outputs
  logic [2:0] osc_q;
  logic osc_hi;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= 3'h0;
    end else if (osc_q == 3'(`AUMX_OSC_PER - 1)) begin
      osc_q <= 3'h0;
    end else begin
      osc_q <= osc_q + 3'h1;
    end
  end

  assign osc_hi = (osc_q < 3'(`AUMX_OSC_HIGH));

  for (genvar c = 0; c < 2; c++) begin : g_cout
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dte_collision_out[c] <= 1'b0;
      end else begin
        dte_collision_out[c] <= (coll_on || jabbed[c] || sqe_on[c]) && osc_hi;
      end
    end
  end

  // ==========================================================
  // Data paths
  logic tx_data;

  assign tx_data = tx_act[0] ? port1_send_in : (tx_act[1] ? port2_send_in : 1'b0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mau_send_out <= 1'b0;
      dte_recv_out <= 2'h0;
    end else begin
      mau_send_out <= tx_data;
      if (loop_en && (|tx_act)) begin
        dte_recv_out <= {2{tx_data}};
      end else if (act_q[2]) begin
        dte_recv_out <= {2{mau_recv_in}};
      end else begin
        dte_recv_out <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Lamp stretchers and lamp pins
  logic [3:0] led_ev;
  logic [3:0] led_on;
  logic [21:0] led_cnt_q [4];

  assign led_ev = {coll_on, act_q[2], tx_act[1], tx_act[0]};

  for (genvar l = 0; l < 4; l++) begin : g_led
    assign led_on[l] = (led_cnt_q[l] != 22'h0);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        led_cnt_q[l] <= 22'h0;
      end else if (led_ev[l]) begin
        led_cnt_q[l] <= 22'(LED_CYC);
      end else if (led_on[l]) begin
        led_cnt_q[l] <= led_cnt_q[l] - 22'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lamps <= '1;
      recv_lamp_cfg_pin_oe <= 1'b0;
      jab_lamp1_cfg_pin_oe <= 1'b0;
    end else begin
      lamps.send_n <= ~led_on[1:0];
      lamps.coll_n <= ~led_on[3];
      lamps.jab_lamp_port2_n <= ~jabbed[1];
      recv_lamp_cfg_pin_oe <= led_on[2] && strap_done_q && (rx_cfg_q == AUMX_LVL_HIGH);
      jab_lamp1_cfg_pin_oe <= jabbed[0] && strap_done_q && !jab_gnd_q;
    end
  end

  assign recv_lamp_cfg_pin_o = 1'b0;
  assign jab_lamp1_cfg_pin_o = 1'b0;

  // ==========================================================
  // AXI4-Lite slave
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_wr;
  aumx_stat_s stat;

  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_q && w_q && !s_axi_bvalid;

  always_comb begin
    stat = '0;
    stat.act = act_q;
    stat.jabbed = jabbed;
    stat.coll = coll_on;
    stat.loop_en = loop_en;
    stat.sqe_en = sqe_en;
    stat.jab_en = jab_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      awaddr_q <= 8'h0;
    end else if (s_axi_awvalid && !aw_q) begin
      aw_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_q <= 1'b0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_q) begin
      w_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `AUMX_RESP_OKAY;
      ctrl_q <= `AUMX_CTRL_RST;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q[7:2] == `AUMX_CTRL_OFS >> 2) begin
        s_axi_bresp <= `AUMX_RESP_OKAY;
        if (wstrb_q[0]) begin
          ctrl_q <= wdata_q[1:0];
        end
      end else if (awaddr_q[7:2] == `AUMX_STAT_OFS >> 2) begin
        s_axi_bresp <= `AUMX_RESP_OKAY;
      end else begin
        s_axi_bresp <= `AUMX_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `AUMX_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[7:2] == `AUMX_CTRL_OFS >> 2) begin
        s_axi_rdata <= {30'h0, ctrl_q};
        s_axi_rresp <= `AUMX_RESP_OKAY;
      end else if (s_axi_araddr[7:2] == `AUMX_STAT_OFS >> 2) begin
        s_axi_rdata <= stat;
        s_axi_rresp <= `AUMX_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `AUMX_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fwd;
    act_q[2] && !(loop_en && (|tx_act)) |=> dte_recv_out == {2{$past(mau_recv_in)}};
  endproperty
  a_fwd: assert property (p_fwd) else $error("receive data not forwarded");

  property p_idle;
    port1_send_in ##1 !port1_send_in [*8] |-> act_q[0];
  endproperty
  a_idle: assert property (p_idle) else $error("receiver dropped before idle time");

  property p_local;
    tx_act[0] && tx_act[1] |-> coll_on ##[1:5] (dte_collision_out != 2'h0);
  endproperty
  a_local: assert property (p_local) else $error("local collision not signalled");

  property p_prio;
    tx_act[0] |=> mau_send_out == $past(port1_send_in);
  endproperty
  a_prio: assert property (p_prio) else $error("port 1 lost send priority");

  property p_osc;
    $rose(dte_collision_out[0]) && coll_on && ($past(osc_q) == 3'h0)
      |=> dte_collision_out[0] ##1 !dte_collision_out[0];
  endproperty
  a_osc: assert property (p_osc) else $error("collision wave high time wrong");

  property p_hold;
    $fell(coll_cond) |-> coll_on [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("collision ended too early");

  property p_sqe_jab;
    jabbed[0] |-> !sqe_on[0];
  endproperty
  a_sqe_jab: assert property (p_sqe_jab) else $error("SQE pulse on jabbed port");

  property p_jdis;
    !jab_en |=> jabbed == 2'h0;
  endproperty
  a_jdis: assert property (p_jdis) else $error("jabber active while disabled");

  property p_blank;
    blank_cnt_q != 8'h0 && act_q[3] && !coll_local && coll_hold_q == 4'h0 && !jabbed[1]
      && !sqe_on[1] |=> !dte_collision_out[1];
  endproperty
  a_blank: assert property (p_blank) else $error("remote collision during blank");

  property p_sqe_start;
    tx_end[0] && sqe_en && !jabbed[0] |=> sqe_cnt_q[0] == 7'(`AUMX_SQE_TOT_CYC);
  endproperty
  a_sqe_start: assert property (p_sqe_start) else $error("SQE test not armed");

  c_local: cover property (tx_act[0] && tx_act[1]);
  c_sqe: cover property ($rose(sqe_on[0]));
  c_jab: cover property ($rose(jabbed[0]));
  c_remote: cover property ($rose(coll_remote));
endmodule

// ===== tb/aumx_link_model.sv
// Far-side model: both DTE senders plus the MAU receive and collision lines.
// Assumes the bench drives go synchronous to aclk; line order p1, p2, mau rx, mau col.
module aumx_link_model (
  input wire logic aclk,
  input wire logic [3:0] go,
  output logic [3:0] line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Line drive
  // Toggle each cycle while sending; idle pulls the pair low
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      line[i] <= go[i] & ~line[i];
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench: AXI4-Lite register access and link scenarios.
// Assumes the far-side model and shortened jabber, unjab and lamp counts.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import aumx_pkg::*;
  // ==========
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] go = 4'h0;
  aumx_lvl_e rpin = AUMX_LVL_GND;
  logic jpin = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, mau_send_out;
  logic rpin_o, rpin_oe, jpin_o, jpin_oe;
  logic [1:0] bresp, rresp, dte_recv_out, dte_collision_out;
  logic [31:0] rdata, rd;
  logic [3:0] line;
  aumx_lamp_s lamps;
  wire logic [4:0] obs = {dte_recv_out, mau_send_out, dte_collision_out};
  int fails = 0, n_tests = 0, c0, c1;

  initial begin
    forever #10 aclk = ~aclk;
  end

  aumx_top #(.JAB_CYC(200), .UNJAB_CYC(100), .LED_CYC(20)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port1_send_in(line[0]), .port2_send_in(line[1]), .mau_recv_in(line[2]),
    .mau_collision_in(line[3]), .mau_send_out(mau_send_out), .dte_recv_out(dte_recv_out),
    .dte_collision_out(dte_collision_out), .recv_lamp_cfg_pin_i(rpin),
    .recv_lamp_cfg_pin_o(rpin_o), .recv_lamp_cfg_pin_oe(rpin_oe), .jab_lamp1_cfg_pin_i(jpin),
    .jab_lamp1_cfg_pin_o(jpin_o), .jab_lamp1_cfg_pin_oe(jpin_oe), .lamps(lamps));

  aumx_link_model link (.aclk(aclk), .go(go), .line(line));

  // ==========
  // Helpers
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up();
    fails++;
    complete_run();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
    logic done;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    if (!done) give_up();
    @(posedge aclk);
  endtask

  // Counts high samples of one observed output
  task automatic cnt_hi(input int b, input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge aclk);
      if (obs[b] === 1'b1) c++;
    end
    @(posedge aclk);
  endtask

  // Output d must repeat input s one cycle later
  task automatic follow(input int s, input int d, input int n);
    logic v;
    @(negedge aclk);
    v = line[s];
    repeat (n) begin
      @(negedge aclk);
      chk(32'(obs[d]), 32'(v));
      v = line[s];
    end
    @(posedge aclk);
  endtask

  task automatic do_reset(input aumx_lvl_e lv, input logic jb);
    aresetn <= 1'b0;
    rpin <= lv;
    jpin <= jb;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
  endtask

  // ==========
  // Scenarios
  initial begin
    @(posedge aclk);
    do_reset(AUMX_LVL_GND, 1'b1);
    chk(32'(lamps), 32'hF);
    chk(32'(dte_collision_out), 32'h0);
    axi_rd(8'h00, 2'h0);
    chk(rd, 32'h3);
    axi_rd(8'h08, 2'h2);
    chk(rd, 32'h0);
    axi_wr(8'h0C, 32'h0000_0003, 2'h2);
    axi_wr(8'h04, 32'hFFFF_FFFF, 2'h0);
    axi_rd(8'h04, 2'h0);
    chk(rd & 32'h380, 32'h380);
    go <= 4'b0100;
    cyc(3);
    follow(2, 3, 10);
    follow(2, 4, 10);
    chk(32'(rpin_oe), 32'h0);
    go <= 4'h0;
    cyc(300);
    go <= 4'b0001;
    cyc(3);
    follow(0, 2, 10);
    follow(0, 4, 10);
    chk(32'(lamps.send_n), 32'h2);
    go <= 4'h0;
    fork
      cnt_hi(0, 150, c0);
      cnt_hi(1, 150, c1);
      begin
        cyc(60);
        go <= 4'b1000;
        cyc(10);
        go <= 4'h0;
      end
    join
    chk(c0, 20);
    chk(c1, 0);
    cyc(300);
    go <= 4'b0010;
    cyc(5);
    go <= 4'b0011;
    cyc(5);
    follow(0, 2, 8);
    cnt_hi(0, 20, c0);
    chk(c0, 8);
    cnt_hi(1, 20, c1);
    chk(c1, 8);
    chk(32'(lamps.coll_n), 32'h0);
    go <= 4'b0010;
    cyc(15);
    follow(1, 2, 8);
    cyc(10);
    cnt_hi(1, 20, c1);
    chk(c1, 0);
    go <= 4'h0;
    cyc(300);
    go <= 4'b1000;
    cyc(4);
    cnt_hi(0, 20, c0);
    chk(c0, 8);
    cnt_hi(1, 20, c1);
    chk(c1, 8);
    go <= 4'h0;
    cyc(50);
    cnt_hi(0, 10, c0);
    chk(c0, 0);
    chk(32'(lamps.coll_n), 32'h1);
    go <= 4'b0001;
    cyc(230);
    cnt_hi(2, 10, c0);
    chk(c0, 0);
    cnt_hi(0, 20, c0);
    chk(c0, 8);
    chk(32'(jpin_oe), 32'h1);
    chk(32'({rpin_o, jpin_o}), 32'h0);
    axi_rd(8'h04, 2'h0);
    chk(rd & 32'h30, 32'h10);
    go <= 4'h0;
    cyc(50);
    go <= 4'b0001;
    cyc(3);
    go <= 4'h0;
    cyc(80);
    chk(32'(jpin_oe), 32'h1);
    cyc(40);
    chk(32'(jpin_oe), 32'h0);
    cnt_hi(0, 10, c0);
    chk(c0, 0);
    cyc(300);
    axi_wr(8'h00, 32'h0000_0000, 2'h0);
    axi_rd(8'h00, 2'h0);
    chk(rd, 32'h0);
    go <= 4'b0001;
    cyc(220);
    follow(0, 2, 8);
    go <= 4'h0;
    cnt_hi(0, 150, c0);
    chk(c0, 0);
    for (int i = 0; i < 3; i++) begin
      cyc(300);
      do_reset(aumx_lvl_e'(i), i == 2);
      axi_rd(8'h04, 2'h0);
      chk(rd & 32'h380, {22'h0, i == 2, i == 0, i != 2, 7'h0});
    end
    go <= 4'b0100;
    cyc(2);
    go <= 4'h0;
    cyc(18);
    chk(32'(rpin_oe), 32'h1);
    cyc(50);
    chk(32'(rpin_oe), 32'h0);
    go <= 4'b0001;
    cnt_hi(3, 20, c0);
    chk(c0, 0);
    go <= 4'h0;
    cyc(20);
    complete_run();
  end
endmodule
